// >>> rtl/qec_pkg.sv
// Constants, register map and types for the quadrature encoder control block.
// Assumes an APB master with 32-bit data; every register takes one aligned word.
//
// Contract
// - Counters run only while counter_enable is one; registers stay accessible.
// - With stop_in_idle set, operation halts while the device is idle.
// - Control bit 14 is unimplemented, reads zero, ignores writes.
// - position_init_mode sits in bits 12:10; 110 is modulo counting, 111 reserved.
// - Mode 101 resets the position counter when it equals the compare register.
// - Mode 100 loads the init value on the second index after home.
// - Mode 011 loads the init value on the first index after home.
// - Mode 010 loads the init value on the next index event.
// - Mode 001 clears the position counter on every index event.
// - Mode 000 leaves the position counter untouched by index events.
// - Index match needs phase B equal to the phase B match bit.
// - Index match needs phase A equal to the phase A match bit 8.
// - Divider in bits 6:4, polarity, gate, count mode in 3:0; all reset zero; only polarity acts, the other bits are just stored.
package qec_pkg;

    localparam logic [7:0]  QEC_CTRL_OFS  = 8'h00;
    localparam logic [7:0]  QEC_POS_OFS   = 8'h04;
    localparam logic [7:0]  QEC_INIT_OFS  = 8'h08;
    localparam logic [7:0]  QEC_GE_OFS    = 8'h0c;
    localparam logic [7:0]  QEC_STAT_OFS  = 8'h10;

    localparam int          QEC_EN_BIT    = 15;
    localparam int          QEC_SIDL_BIT  = 13;
    localparam int          QEC_PIM_HI    = 12;
    localparam int          QEC_PIM_LO    = 10;
    localparam int          QEC_IMB_BIT   = 9;
    localparam int          QEC_IMA_BIT   = 8;
    localparam int          QEC_POL_BIT   = 3;

    localparam logic [15:0] QEC_CTRL_RST  = 16'h0000;
    localparam logic [15:0] QEC_CTRL_MASK = 16'hbf7f;
    localparam logic [31:0] QEC_ZERO32    = 32'h0000_0000;

    typedef enum logic [2:0] {
        PIM_NONE  = 3'b000,
        PIM_CLR   = 3'b001,
        PIM_NEXT  = 3'b010,
        PIM_HOME1 = 3'b011,
        PIM_HOME2 = 3'b100,
        PIM_GE    = 3'b101,
        PIM_MOD   = 3'b110,
        PIM_RSV   = 3'b111
    } qec_pim_t;

    typedef enum logic [2:0] {
        HS_IDLE = 3'b001,
        HS_ARM1 = 3'b010,
        HS_ARM2 = 3'b100
    } qec_home_t;

endpackage

// >>> rtl/qec_sync.sv
// Two-flop synchroniser for a group of asynchronous level inputs.
// Assumes the inputs change slowly relative to clk.
`timescale 1ns/1ps
module qec_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // Levels
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// >>> rtl/qec_top.sv
// Quadrature encoder position counter with index and home initialisation.
// Assumes an APB master on clk and asynchronous encoder pins.
`timescale 1ns/1ps
module qec_top
    import qec_pkg::*;
#(
    parameter int CW = 32
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Encoder pins
    input  wire logic        phase_a_input,
    input  wire logic        phase_b_input,
    input  wire logic        index_input,
    input  wire logic        home_input,
    // Device state
    input  wire logic        idle_mode,
    // Status outputs
    output logic [CW-1:0]    position_count,
    output logic             index_event,
    output logic             counter_running
);

    logic [15:0]   ctrl_q;
    logic [CW-1:0] pos_q;
    logic [CW-1:0] pos_d;
    logic [CW-1:0] init_q;
    logic [CW-1:0] ge_q;
    logic [3:0]    sync_s;
    logic          a_p_q;
    logic          b_p_q;
    logic          match_p_q;
    logic          home_p_q;
    logic          idle_q;
    qec_home_t     hs_q;
    qec_home_t     hs_d;
    logic [31:0]   rd_d;

    // Encoder inputs enter through the synchroniser.
    qec_sync #(
        .W    (4)
    ) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     ({home_input, index_input, phase_b_input, phase_a_input}),
        .dout    (sync_s)
    );

    wire       a_s       = sync_s[0];
    wire       b_s       = sync_s[1];
    wire       idx_s     = sync_s[2];
    wire       home_s    = sync_s[3];

    // Control fields.
    wire       en_bit    = ctrl_q[QEC_EN_BIT];
    wire       sidl_bit  = ctrl_q[QEC_SIDL_BIT];
    wire [2:0] pim_raw   = ctrl_q[QEC_PIM_HI:QEC_PIM_LO];
    wire       imv_b     = ctrl_q[QEC_IMB_BIT];
    wire       imv_a     = ctrl_q[QEC_IMA_BIT];
    wire       pol_bit   = ctrl_q[QEC_POL_BIT];
    qec_pim_t  pim;
    assign pim = qec_pim_t'(pim_raw);

    // Idle only stops the block when stop_in_idle is set.
    wire       halt      = idle_q & sidl_bit;
    wire       run       = en_bit & ~halt;

    // APB decode; one wait state before every answer.
    wire       acc       = psel & penable;
    wire       fin       = acc & pready;
    wire       wr        = fin & pwrite;
    wire       sel_ctrl  = paddr == QEC_CTRL_OFS;
    wire       sel_pos   = paddr == QEC_POS_OFS;
    wire       sel_init  = paddr == QEC_INIT_OFS;
    wire       sel_ge    = paddr == QEC_GE_OFS;
    wire       sel_stat  = paddr == QEC_STAT_OFS;
    wire       mapped    = sel_ctrl | sel_pos | sel_init | sel_ge | sel_stat;
    wire       wr_ctrl   = wr & sel_ctrl;
    wire       wr_pos    = wr & sel_pos;
    wire       wr_init   = wr & sel_init;
    wire       wr_ge     = wr & sel_ge;

    // Index match needs both phase levels at their programmed values.
    wire       match_s   = idx_s & (b_s == imv_b) & (a_s == imv_a);
    wire       idx_evt   = run & match_s & ~match_p_q;
    wire       home_evt  = run & home_s & ~home_p_q;

    // Quadrature x4 decode; polarity flips the direction.
    wire       step      = a_s ^ a_p_q ^ b_s ^ b_p_q;
    wire       up        = (a_p_q ^ b_s) ^ pol_bit;
    wire       cnt_step  = run & step;

    wire       at_ge     = pos_q == ge_q;
    wire       at_zero   = pos_q == '0;
    wire       ld_home1  = idx_evt & (hs_q == HS_ARM1) & (pim == PIM_HOME1);
    wire       ld_home2  = idx_evt & (hs_q == HS_ARM2) & (pim == PIM_HOME2);
    wire       ld_next   = idx_evt & (pim == PIM_NEXT);
    wire       clr_idx   = idx_evt & (pim == PIM_CLR);
    wire       clr_ge    = run & (pim == PIM_GE) & at_ge;

    // Home sequencing for the two home-referenced modes.
    always_comb begin
        hs_d = hs_q;
        case (hs_q)
            HS_IDLE: begin
                if (home_evt) begin
                    hs_d = HS_ARM1;
                end
            end
            HS_ARM1: begin
                if (home_evt) begin
                    hs_d = HS_ARM1;
                end else if (idx_evt) begin
                    hs_d = (pim == PIM_HOME2) ? HS_ARM2 : HS_IDLE;
                end
            end
            HS_ARM2: begin
                if (home_evt) begin
                    hs_d = HS_ARM1;
                end else if (idx_evt) begin
                    hs_d = HS_IDLE;
                end
            end
            default: begin
                hs_d = HS_IDLE;
            end
        endcase
    end

    // Software write wins, then index or compare events, then counting.
    always_comb begin
        pos_d = pos_q;
        if (wr_pos) begin
            pos_d = pwdata[CW-1:0];
        end else if (ld_home1 | ld_home2 | ld_next) begin
            pos_d = init_q;
        end else if (clr_idx) begin
            pos_d = '0;
        end else if (clr_ge) begin
            pos_d = '0;
        end else if (cnt_step) begin
            if (pim == PIM_MOD && up && at_ge) begin
                pos_d = '0;
            end else if (pim == PIM_MOD && !up && at_zero) begin
                pos_d = ge_q;
            end else if (up) begin
                pos_d = pos_q + 1'b1;
            end else begin
                pos_d = pos_q - 1'b1;
            end
        end
        // Mode 000 and reserved mode fall through: index has no effect.
    end

    // Read mux; bit 14 and the other unimplemented bits read zero.
    always_comb begin
        rd_d = QEC_ZERO32;
        case (1'b1)
            sel_ctrl: rd_d = {16'h0000, ctrl_q & QEC_CTRL_MASK};
            sel_pos:  rd_d = 32'(pos_q);
            sel_init: rd_d = 32'(init_q);
            sel_ge:   rd_d = 32'(ge_q);
            sel_stat: rd_d = {24'h00_0000, hs_q, run, home_s, idx_s, b_s, a_s};
            default:  rd_d = QEC_ZERO32;
        endcase
    end

    // Control and reference registers.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= QEC_CTRL_RST;
            init_q <= '0;
            ge_q   <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= pwdata[15:0] & QEC_CTRL_MASK;
            end
            if (wr_init) begin
                init_q <= pwdata[CW-1:0];
            end
            if (wr_ge) begin
                ge_q <= pwdata[CW-1:0];
            end
        end
    end

    // Counter, edge history and home state.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pos_q     <= '0;
            hs_q      <= HS_IDLE;
            a_p_q     <= 1'b0;
            b_p_q     <= 1'b0;
            match_p_q <= 1'b0;
            home_p_q  <= 1'b0;
            idle_q    <= 1'b0;
        end else begin
            pos_q     <= pos_d;
            hs_q      <= hs_d;
            a_p_q     <= a_s;
            b_p_q     <= b_s;
            match_p_q <= match_s;
            home_p_q  <= home_s;
            idle_q    <= idle_mode;
        end
    end

    // APB answer registers.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            prdata  <= QEC_ZERO32;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc & ~pready;
            prdata  <= (acc & ~pready & ~pwrite) ? rd_d : QEC_ZERO32;
            pslverr <= acc & ~pready & ~mapped;
        end
    end

    // Status outputs.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            position_count  <= '0;
            index_event     <= 1'b0;
            counter_running <= 1'b0;
        end else begin
            position_count  <= pos_d;
            index_event     <= idx_evt;
            counter_running <= run;
        end
    end

    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    hold_when_off_a: assert property (
        !en_bit && !wr_pos |=> pos_q == $past(pos_q))
        else $error("Counter moved while disabled.");

    idle_halt_a: assert property (
        idle_q && sidl_bit && !wr_pos |=> pos_q == $past(pos_q))
        else $error("Block ran during idle with stop set.");

    idle_run_a: assert property (
        idle_q && !sidl_bit && en_bit |=> counter_running)
        else $error("Block stopped in idle without stop set.");

    bit14_zero_a: assert property (
        wr_ctrl |=> !ctrl_q[14])
        else $error("Unimplemented control bit was stored.");

    ge_reset_a: assert property (
        run && pim == PIM_GE && at_ge && !wr_pos && !idx_evt |=> pos_q == '0)
        else $error("Compare match did not clear the counter.");

    next_load_a: assert property (
        idx_evt && pim == PIM_NEXT && !wr_pos |=> pos_q == $past(init_q))
        else $error("Index did not load the init value.");

    clear_idx_a: assert property (
        idx_evt && pim == PIM_CLR && !wr_pos |=> pos_q == '0)
        else $error("Index did not clear the counter.");

    idx_ignore_a: assert property (
        idx_evt && pim == PIM_NONE && !wr_pos && !step |=> pos_q == $past(pos_q))
        else $error("Index changed the counter in mode 000.");

    home2_seq_a: assert property (
        hs_q == HS_ARM1 && idx_evt && pim == PIM_HOME2 && !home_evt |=> hs_q == HS_ARM2)
        else $error("First index after home did not arm the second.");

    match_lvl_a: assert property (
        run && !match_p_q && idx_s && (b_s != imv_b || a_s != imv_a) |=> !index_event)
        else $error("Index event with wrong phase levels.");

    // A software write of the position wins over every mode, so these checks exclude it.
    mod_up_a: assert property (
        cnt_step && pim == PIM_MOD && up && at_ge && !wr_pos |=> pos_q == '0)
        else $error("Modulo count did not wrap to zero.");

    mod_down_a: assert property (
        cnt_step && pim == PIM_MOD && !up && at_zero && !wr_pos |=> pos_q == $past(ge_q))
        else $error("Modulo count did not wrap to the compare value.");

    home1_load_a: assert property (
        idx_evt && hs_q == HS_ARM1 && pim == PIM_HOME1 && !wr_pos |=> pos_q == $past(init_q))
        else $error("First index after home did not load.");

    home2_load_a: assert property (
        idx_evt && hs_q == HS_ARM2 && pim == PIM_HOME2 && !wr_pos |=> pos_q == $past(init_q))
        else $error("Second index after home did not load.");

    home_arm_a: assert property (
        home_evt |=> hs_q == HS_ARM1)
        else $error("Home event did not arm the sequence.");

    ctrl_reset_a: assert property (
        disable iff (1'b0) sys_rst |=> ctrl_q == QEC_CTRL_RST)
        else $error("Control register not cleared by reset.");

    bit7_zero_a: assert property (
        wr_ctrl |=> !ctrl_q[7])
        else $error("Unimplemented control bit 7 was stored.");

    sync_delay_a: assert property (
        a_s == $past(phase_a_input, 2) && idx_s == $past(index_input, 2))
        else $error("Encoder input not delayed by two flops.");

    run_flag_a: assert property (
        counter_running == $past(run))
        else $error("Running flag does not follow enable.");

    idx_pulse_a: assert property (
        index_event == $past(idx_evt))
        else $error("Index event output lost a match.");

    pos_out_a: assert property (
        position_count == pos_q)
        else $error("Position output differs from the counter.");

    err_read_a: assert property (
        fin && !mapped |-> pslverr && prdata == QEC_ZERO32)
        else $error("Unmapped access answered without error.");

    apb_wait_a: assert property (
        acc && !pready |=> pready ##1 !pready)
        else $error("Answer not after exactly one wait state.");

    home1_cv: cover property (home_evt ##[1:50] ld_home1);
    home2_cv: cover property (home_evt ##[1:80] ld_home2);
    mod_wrap_cv: cover property (cnt_step && pim == PIM_MOD && at_ge && up);
    err_cv: cover property (pslverr);
    ge_clear_cv: cover property (clr_ge);

endmodule

// >>> testbench/qec_enc_model.sv
// Behavioural incremental encoder driving phase, index and home pins.
// Assumes its tasks are called from one bench process synchronised to clk.
`timescale 1ns/1ps
module qec_enc_model (
    // Clock
    input  wire logic clk,
    // Encoder pins
    output logic      phase_a,
    output logic      phase_b,
    output logic      index_pin,
    output logic      home_pin
);
    logic [1:0] pos_q = 2'h0;
    logic [1:0] gray;

    initial begin
        phase_a = 1'b0;
        phase_b = 1'b0;
        index_pin = 1'b0;
        home_pin = 1'b0;
    end

    // Gray order 00,01,11,10 on A,B counts up; holds each state 6 clocks.
    task automatic step(input bit up, input int n);
        for (int i = 0; i < n; i++) begin
            pos_q = up ? pos_q + 2'h1 : pos_q - 2'h1;
            gray = pos_q ^ (pos_q >> 1);
            @(posedge clk);
            {phase_a, phase_b} <= gray;
            repeat (5) @(posedge clk);
        end
    endtask

    // Pins are held well past the two-clock synchroniser delay.
    task automatic pulse(input bit home);
        @(posedge clk);
        if (home) home_pin <= 1'b1;
        else index_pin <= 1'b1;
        repeat (4) @(posedge clk);
        home_pin <= 1'b0;
        index_pin <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
endmodule

// >>> testbench/tb_qec_top.sv
// Self-checking bench for the encoder control block over APB.
// Assumes the encoder model file is compiled first.
`timescale 1ns/1ps
module tb_qec_top
    import qec_pkg::*;
;
    logic        clk;
    logic        sys_rst;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pa, pb, idx, home;
    logic        idle_mode;
    logic [31:0] idx_cnt;
    logic [31:0] position_count;
    logic        index_event;
    logic        counter_running;
    logic [31:0] rd;
    logic        er;
    int          fails = 0;
    int          comparisons = 0;
    int          cyc = 0;

    always #2.5 clk = ~clk;

    qec_top i_qec_top (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .phase_a_input(pa), .phase_b_input(pb), .index_input(idx), .home_input(home),
        .idle_mode(idle_mode), .position_count(position_count), .index_event(index_event),
        .counter_running(counter_running));

    qec_enc_model i_qec_enc_model (.clk(clk), .phase_a(pa), .phase_b(pb), .index_pin(idx), .home_pin(home));

    task automatic finish_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Request is held until pready is sampled high at a rising edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask

    task automatic setc(input logic [2:0] m, input logic [1:0] v, input logic s);
        apb(1'b1, QEC_CTRL_OFS, {16'h0000, 1'b1, 1'b0, s, m, v, 8'h00});
    endtask

    // Index pulses last one cycle, so they are counted here rather than polled.
    always @(posedge clk) begin
        if (sys_rst) idx_cnt <= 32'h0000_0000;
        else if (index_event === 1'b1) idx_cnt <= idx_cnt + 32'h0000_0001;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0000_0000;
        idle_mode = 1'b0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        rdchk(QEC_CTRL_OFS, 32'h0000_0000);
        apb(1'b1, QEC_CTRL_OFS, 32'hffff_ffff);
        rdchk(QEC_CTRL_OFS, 32'h0000_bf7f);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk({31'h0000_0000, er}, 32'h0000_0001);
        apb(1'b1, QEC_CTRL_OFS, 32'h0000_0000);
        // Disabled counter ignores two steps; phases end at A=1, B=1.
        i_qec_enc_model.step(1'b1, 2);
        rdchk(QEC_POS_OFS, 32'h0000_0000);
        setc(PIM_NONE, 2'h3, 1'b0);
        i_qec_enc_model.step(1'b1, 4);
        rdchk(QEC_POS_OFS, 32'h0000_0004);
        chk({31'h0000_0000, counter_running}, 32'h0000_0001);
        i_qec_enc_model.pulse(1'b0);
        rdchk(QEC_POS_OFS, 32'h0000_0004);
        chk(idx_cnt, 32'h0000_0001);
        setc(PIM_CLR, 2'h1, 1'b0);
        i_qec_enc_model.pulse(1'b0);
        rdchk(QEC_POS_OFS, 32'h0000_0004);
        setc(PIM_CLR, 2'h2, 1'b0);
        i_qec_enc_model.pulse(1'b0);
        rdchk(QEC_POS_OFS, 32'h0000_0004);
        chk(idx_cnt, 32'h0000_0001);
        setc(PIM_CLR, 2'h3, 1'b0);
        i_qec_enc_model.pulse(1'b0);
        rdchk(QEC_POS_OFS, 32'h0000_0000);
        apb(1'b1, QEC_INIT_OFS, 32'h0000_0055);
        setc(PIM_NEXT, 2'h3, 1'b0);
        i_qec_enc_model.pulse(1'b0);
        rdchk(QEC_POS_OFS, 32'h0000_0055);
        chk(position_count, 32'h0000_0055);
        apb(1'b1, QEC_POS_OFS, 32'h0000_0000);
        setc(PIM_HOME1, 2'h3, 1'b0);
        i_qec_enc_model.pulse(1'b0);
        rdchk(QEC_POS_OFS, 32'h0000_0000);
        i_qec_enc_model.pulse(1'b1);
        i_qec_enc_model.pulse(1'b0);
        rdchk(QEC_POS_OFS, 32'h0000_0055);
        apb(1'b1, QEC_POS_OFS, 32'h0000_0000);
        setc(PIM_HOME2, 2'h3, 1'b0);
        i_qec_enc_model.pulse(1'b1);
        i_qec_enc_model.pulse(1'b0);
        rdchk(QEC_POS_OFS, 32'h0000_0000);
        i_qec_enc_model.pulse(1'b0);
        rdchk(QEC_POS_OFS, 32'h0000_0055);
        chk(idx_cnt, 32'h0000_0007);
        apb(1'b1, QEC_POS_OFS, 32'h0000_0000);
        setc(PIM_NONE, 2'h3, 1'b1);
        idle_mode <= 1'b1;
        i_qec_enc_model.step(1'b1, 1);
        rdchk(QEC_POS_OFS, 32'h0000_0000);
        setc(PIM_NONE, 2'h3, 1'b0);
        i_qec_enc_model.step(1'b1, 1);
        rdchk(QEC_POS_OFS, 32'h0000_0001);
        idle_mode <= 1'b0;
        // Count passes the compare value once, so a missing clear shows as 4.
        apb(1'b1, QEC_GE_OFS, 32'h0000_0003);
        apb(1'b1, QEC_POS_OFS, 32'h0000_0000);
        setc(PIM_GE, 2'h3, 1'b0);
        i_qec_enc_model.step(1'b1, 4);
        rdchk(QEC_POS_OFS, 32'h0000_0001);
        apb(1'b1, QEC_GE_OFS, 32'h0000_0002);
        apb(1'b1, QEC_POS_OFS, 32'h0000_0000);
        setc(PIM_MOD, 2'h3, 1'b0);
        i_qec_enc_model.step(1'b0, 1);
        rdchk(QEC_POS_OFS, 32'h0000_0002);
        i_qec_enc_model.step(1'b1, 1);
        rdchk(QEC_POS_OFS, 32'h0000_0000);
        finish_test();
    end
endmodule
